// >>> rtl/acrpm_pkg.sv
// constants and types for converter control, readout and power modes
package acrpm_pkg;

  // result word
  localparam int unsigned RES_W      = 16;
  localparam int unsigned IDX_W      = 5;
  localparam logic [IDX_W-1:0] IDX_DONE = 5'h10;
  localparam logic [3:0]       IDX_MSB  = 4'hf;

  // reference clock rate and internal conversion time
  localparam int unsigned CLK_MHZ    = 100;
  localparam int unsigned T_CONV_NS  = 300;
  // least time, rounded up to whole reference cycles
  localparam int unsigned CONV_CYC   = (T_CONV_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned TMR_W      = 6;
  localparam logic [TMR_W-1:0] CONV_CYC_V = TMR_W'(CONV_CYC);
  localparam logic [TMR_W-1:0] TMR_LAST   = 6'h01;
  localparam logic [TMR_W-1:0] TMR_IDLE   = 6'h00;

  // strobe pulse counts since the last serial clock activity
  localparam int unsigned PC_W       = 3;
  localparam logic [PC_W-1:0] PC_INIT  = 3'h0;
  localparam logic [PC_W-1:0] PC_NAP   = 3'h1;
  localparam logic [PC_W-1:0] PC_SLEEP = 3'h3;
  localparam logic [PC_W-1:0] PC_WAKE  = 3'h4;
  localparam logic [PC_W-1:0] PC_ONE   = 3'h1;

  // power modes
  typedef enum logic [1:0] {
    MODE_OPER,
    MODE_NAP,
    MODE_SLEEP
  } acrpm_mode_t;

endpackage : acrpm_pkg

// >>> rtl/acrpm_sync3.sv
// three-stage pin synchroniser, output moves when stages two and three agree
`timescale 1ns/1ns
module acrpm_sync3 #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_async,
  output logic      o_sync
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  // shift chain; the first stage feeds only the second
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
    end else begin
      s1_r <= i_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // accept a new level only once it has stood two samples
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_sync <= RST_VAL;
    end else if (s2_r == s3_r) begin
      o_sync <= s3_r;
    end
  end

endmodule : acrpm_sync3

// >>> rtl/acrpm_core.sv
// converter control, serial readout and nap/sleep sequencing
//
// Behaviour
// - a falling strobe edge at full power, with no conversion running, starts a conversion
// - conversion is timed internally, no host clock needed
// - result leaves MSB first, one bit per falling serial clock edge
// - second strobe rising edge of the series enters nap
// - nap lasts until serial clock rise (wakes) or more strobe pulses
// - in nap, two further strobe pulses enter sleep
// - single-ended mode: one serial clock rise leaves sleep
// - fifth strobe pulse leaves sleep, in either signalling mode
// - serial clock activity between strobes blocks nap and sleep
// - idle serial clock: strobes cycle operational, nap, sleep forever
// - reset at power-up or brown-out, then reinitialise
// - select pin chooses single-ended or differential signalling
// - single-ended: only positive data and clock used, negative held low
// - differential: data outputs work as a complementary pair, serial clock stays a single input
`timescale 1ns/1ns
module acrpm_core (
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_rstn,
  input  wire logic                     i_sck,
  input  wire logic                     i_conv_strobe_n,
  input  wire logic                     i_diff_sel,
  input  wire logic [acrpm_pkg::RES_W-1:0] i_sample_data,
  output logic                          o_serial_out_pos,
  output logic                          o_serial_out_neg,
  output logic                          o_conv_busy,
  output logic                          o_nap,
  output logic                          o_sleep
);

  // synchronised pins and link events
  logic                            strobe_s;
  logic                            strobe_d_r;
  logic                            diff_s;
  logic                            sck_tog_r;
  logic                            sck_tog_s;
  logic                            sck_tog_d_r;
  logic                            strobe_fall;
  logic                            strobe_rise;
  logic                            sck_ev;

  // conversion
  logic                            conv_busy_r;
  logic [acrpm_pkg::TMR_W-1:0]     conv_tmr_r;
  logic [acrpm_pkg::RES_W-1:0]     result_r;
  logic                            conv_start;
  logic                            rd_clr_r;

  // power mode sequencing
  acrpm_pkg::acrpm_mode_t          mode_r;
  acrpm_pkg::acrpm_mode_t          mode_nxt;
  logic [acrpm_pkg::PC_W-1:0]      pulse_cnt_r;
  logic [acrpm_pkg::PC_W-1:0]      pulse_cnt_nxt;
  logic                            nap_r;
  logic                            sleep_r;

  // readout on the serial clock
  logic [acrpm_pkg::IDX_W-1:0]     rd_idx_r;
  logic [3:0]                      rd_idx_lo;
  logic                            serial_pos_r;
  logic                            serial_neg_r;
  logic                            rd_bit;

  // strobe pin, idles high
  acrpm_sync3 #(
    .RST_VAL (1'b1)
  ) u_sync_strobe (
    .i_clk   (i_ref_clk),
    .i_rstn  (i_rstn),
    .i_async (i_conv_strobe_n),
    .o_sync  (strobe_s)
  );

  // signalling select pin
  acrpm_sync3 #(
    .RST_VAL (1'b0)
  ) u_sync_diff (
    .i_clk   (i_ref_clk),
    .i_rstn  (i_rstn),
    .i_async (i_diff_sel),
    .o_sync  (diff_s)
  );

  // serial clock rising edges, as a toggle from the link domain
  acrpm_sync3 #(
    .RST_VAL (1'b0)
  ) u_sync_sck (
    .i_clk   (i_ref_clk),
    .i_rstn  (i_rstn),
    .i_async (sck_tog_r),
    .o_sync  (sck_tog_s)
  );

  // link domain: every rising serial clock edge flips the toggle
  always_ff @(posedge i_sck or negedge i_rstn) begin
    if (!i_rstn) begin
      sck_tog_r <= 1'b0;
    end else begin
      sck_tog_r <= ~sck_tog_r;
    end
  end

  // previous values for edge detection
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      strobe_d_r  <= 1'b1;
      sck_tog_d_r <= 1'b0;
    end else begin
      strobe_d_r  <= strobe_s;
      sck_tog_d_r <= sck_tog_s;
    end
  end

  // edge events
  assign strobe_fall = strobe_d_r & ~strobe_s;
  assign strobe_rise = ~strobe_d_r & strobe_s;
  assign sck_ev      = sck_tog_s ^ sck_tog_d_r;
  // conversions start only at full power
  assign conv_start  = strobe_fall && (mode_r == acrpm_pkg::MODE_OPER)
                       && !conv_busy_r;

  // internally timed conversion, result captured at its end
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      conv_busy_r <= 1'b0;
      conv_tmr_r  <= acrpm_pkg::TMR_IDLE;
      result_r    <= '0;
    end else if (conv_start) begin
      conv_busy_r <= 1'b1;
      conv_tmr_r  <= acrpm_pkg::CONV_CYC_V;
    end else if (conv_busy_r) begin
      conv_tmr_r <= conv_tmr_r - acrpm_pkg::TMR_LAST;
      if (conv_tmr_r == acrpm_pkg::TMR_LAST) begin
        conv_busy_r <= 1'b0;
        result_r    <= i_sample_data;
      end
    end
  end

  // clears the readout while a conversion runs or reset holds
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rd_clr_r <= 1'b1;
    end else begin
      rd_clr_r <= conv_start | conv_busy_r;
    end
  end

  // next power mode from strobe pulses and serial clock activity
  always_comb begin
    mode_nxt      = mode_r;
    pulse_cnt_nxt = pulse_cnt_r;
    case (mode_r)
      acrpm_pkg::MODE_OPER: begin
        if (sck_ev) begin
          pulse_cnt_nxt = acrpm_pkg::PC_INIT;
        end else if (strobe_rise) begin
          if (pulse_cnt_r == acrpm_pkg::PC_NAP) begin
            mode_nxt = acrpm_pkg::MODE_NAP;
          end
          pulse_cnt_nxt = pulse_cnt_r + acrpm_pkg::PC_ONE;
        end
      end
      acrpm_pkg::MODE_NAP: begin
        if (sck_ev) begin
          mode_nxt      = acrpm_pkg::MODE_OPER;
          pulse_cnt_nxt = acrpm_pkg::PC_INIT;
        end else if (strobe_rise) begin
          if (pulse_cnt_r == acrpm_pkg::PC_SLEEP) begin
            mode_nxt = acrpm_pkg::MODE_SLEEP;
          end
          pulse_cnt_nxt = pulse_cnt_r + acrpm_pkg::PC_ONE;
        end
      end
      acrpm_pkg::MODE_SLEEP: begin
        if (sck_ev && !diff_s) begin
          mode_nxt      = acrpm_pkg::MODE_OPER;
          pulse_cnt_nxt = acrpm_pkg::PC_INIT;
        end else if (strobe_rise
                     && pulse_cnt_r == acrpm_pkg::PC_WAKE) begin
          mode_nxt      = acrpm_pkg::MODE_OPER;
          pulse_cnt_nxt = acrpm_pkg::PC_INIT;
        end
      end
      default: begin
        mode_nxt      = acrpm_pkg::MODE_OPER;
        pulse_cnt_nxt = acrpm_pkg::PC_INIT;
      end
    endcase
  end

  // power mode state and its status flops
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode_r      <= acrpm_pkg::MODE_OPER;
      pulse_cnt_r <= acrpm_pkg::PC_INIT;
      nap_r       <= 1'b0;
      sleep_r     <= 1'b0;
    end else begin
      mode_r      <= mode_nxt;
      pulse_cnt_r <= pulse_cnt_nxt;
      nap_r       <= (mode_nxt == acrpm_pkg::MODE_NAP);
      sleep_r     <= (mode_nxt == acrpm_pkg::MODE_SLEEP);
    end
  end

  // bit under the read index; result_r stands still during readout
  assign rd_idx_lo = rd_idx_r[3:0];
  assign rd_bit    = result_r[acrpm_pkg::IDX_MSB - rd_idx_lo];

  // link domain: shift the result out on falling serial clock edges
  always_ff @(negedge i_sck or posedge rd_clr_r) begin
    if (rd_clr_r) begin
      rd_idx_r     <= '0;
      serial_pos_r <= 1'b0;
      serial_neg_r <= 1'b0;
    end else if (rd_idx_r != acrpm_pkg::IDX_DONE) begin
      rd_idx_r     <= rd_idx_r + 5'h01;
      serial_pos_r <= rd_bit;
      serial_neg_r <= diff_s ? ~rd_bit : 1'b0;
    end else begin
      serial_pos_r <= 1'b0;
      serial_neg_r <= 1'b0;
    end
  end

  // outputs straight from flops
  assign o_serial_out_pos = serial_pos_r;
  assign o_serial_out_neg = serial_neg_r;
  assign o_conv_busy      = conv_busy_r;
  assign o_nap            = nap_r;
  assign o_sleep          = sleep_r;

  // checks in the reference domain, each naming its clock and reset

  conv_start_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    strobe_fall && mode_r == acrpm_pkg::MODE_OPER && !conv_busy_r
    |=> conv_busy_r && conv_tmr_r == acrpm_pkg::CONV_CYC_V)
    else $error("strobe fall did not start a conversion");

  conv_time_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    $rose(conv_busy_r) |-> conv_busy_r[*8] ##[1:40] !conv_busy_r)
    else $error("conversion time out of range");

  nap_entry_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    mode_r == acrpm_pkg::MODE_OPER && pulse_cnt_r == acrpm_pkg::PC_NAP
    && strobe_rise && !sck_ev |=> o_nap && mode_r == acrpm_pkg::MODE_NAP)
    else $error("second strobe rise did not enter nap");

  nap_wake_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    mode_r == acrpm_pkg::MODE_NAP && sck_ev
    |=> mode_r == acrpm_pkg::MODE_OPER && !o_nap)
    else $error("serial clock rise did not end nap");

  sleep_entry_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    mode_r == acrpm_pkg::MODE_NAP && pulse_cnt_r == acrpm_pkg::PC_SLEEP
    && strobe_rise && !sck_ev |=> o_sleep ##1 o_sleep)
    else $error("two more strobe pulses did not enter sleep");

  se_wake_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    mode_r == acrpm_pkg::MODE_SLEEP && sck_ev && !diff_s
    |=> mode_r == acrpm_pkg::MODE_OPER && !o_sleep)
    else $error("serial clock rise did not end sleep");

  fifth_wake_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    mode_r == acrpm_pkg::MODE_SLEEP && pulse_cnt_r == acrpm_pkg::PC_WAKE
    && strobe_rise |=> !o_sleep && pulse_cnt_r == acrpm_pkg::PC_INIT)
    else $error("fifth strobe pulse did not end sleep");

  sck_hold_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    mode_r == acrpm_pkg::MODE_OPER && sck_ev
    |=> mode_r == acrpm_pkg::MODE_OPER && pulse_cnt_r == acrpm_pkg::PC_INIT)
    else $error("serial clock activity did not hold full power");

  diff_sleep_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    mode_r == acrpm_pkg::MODE_SLEEP && diff_s && !strobe_rise
    |=> $stable(mode_r))
    else $error("differential sleep left without a strobe pulse");

  reset_idle_a: assert property (
    @(posedge i_ref_clk)
    !i_rstn |-> !o_conv_busy && !o_nap && !o_sleep
    && mode_r == acrpm_pkg::MODE_OPER)
    else $error("reset did not return to full power");

  conv_hold_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    conv_busy_r && conv_tmr_r != acrpm_pkg::TMR_LAST
    |=> conv_busy_r
    && conv_tmr_r == $past(conv_tmr_r) - acrpm_pkg::TMR_LAST)
    else $error("conversion timer did not count down");

  idle_no_conv_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    mode_r != acrpm_pkg::MODE_OPER && !conv_busy_r
    |=> !conv_busy_r)
    else $error("conversion started outside full power");

  mode_excl_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    !(o_nap && o_sleep))
    else $error("nap and sleep shown together");

  clr_busy_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rstn)
    conv_busy_r |=> rd_clr_r)
    else $error("readout not held clear during conversion");

  // checks on the link clock
  readout_bit_a: assert property (
    @(negedge i_sck) disable iff (rd_clr_r)
    rd_idx_r != acrpm_pkg::IDX_DONE
    |=> serial_pos_r == result_r[acrpm_pkg::IDX_MSB - $past(rd_idx_lo)])
    else $error("serial bit out of order");

  neg_quiet_a: assert property (
    @(negedge i_sck) disable iff (rd_clr_r)
    !diff_s |=> !serial_neg_r)
    else $error("negative output driven in single-ended mode");

  neg_pair_a: assert property (
    @(negedge i_sck) disable iff (rd_clr_r)
    diff_s && rd_idx_r != acrpm_pkg::IDX_DONE
    |=> serial_neg_r == ~serial_pos_r)
    else $error("differential pair not complementary");

  read_done_a: assert property (
    @(negedge i_sck) disable iff (rd_clr_r)
    rd_idx_r == acrpm_pkg::IDX_DONE
    |=> !serial_pos_r && !serial_neg_r)
    else $error("serial output not idle after last bit");

endmodule : acrpm_core

// >>> dv/acrpm_host.sv
// host model: drives conversion strobe and serial clock, reads result
`timescale 1ns/1ns
module acrpm_host (
  input  wire logic i_ref_clk,
  input  wire logic i_serial_out_pos,
  input  wire logic i_serial_out_neg,
  output logic      o_sck,
  output logic      o_conv_strobe_n
);
  // serial clock rests low, strobe idles high
  initial begin
    o_sck = 1'b0;
    o_conv_strobe_n = 1'b1;
  end

  // one strobe pulse, low for 40ns, serial clock held still
  task automatic strobe();
    @(negedge i_ref_clk);
    o_conv_strobe_n = 1'b0;
    repeat (4) @(negedge i_ref_clk);
    o_conv_strobe_n = 1'b1;
    repeat (8) @(negedge i_ref_clk);
  endtask : strobe

  // a single serial clock pulse, off the reference phase
  task automatic sck_rise();
    #3;
    o_sck = 1'b1;
    #7;
    o_sck = 1'b0;
    repeat (8) @(negedge i_ref_clk);
  endtask : sck_rise

  // one falling edge per result bit, plus one spare edge
  task automatic read_word(output logic [15:0] pos, output logic [15:0] neg,
                           output logic spare);
    #3;
    for (int i = 16; i >= 0; i--) begin
      o_sck = 1'b1; // 15ns link period
      #7;
      o_sck = 1'b0;
      #8;
      if (i == 0) spare = i_serial_out_pos;
      else begin
        pos[i-1] = i_serial_out_pos;
        neg[i-1] = i_serial_out_neg;
      end
    end
    repeat (4) @(negedge i_ref_clk);
  endtask : read_word
endmodule : acrpm_host

// >>> dv/acrpm_tb_top.sv
// self-checking bench for conversion, readout and power modes
`timescale 1ns/1ns
module acrpm_tb_top;
  logic        i_ref_clk;
  logic        i_rstn;
  logic        i_diff_sel;
  logic [15:0] i_sample_data;
  logic        sck;
  logic        strobe_n;
  logic        pos;
  logic        neg;
  logic        busy;
  logic        nap;
  logic        sleep;
  int          num_errors;
  int          tests_run;
  int          cycles;
  int          busy_len;

  // reference clock, 10ns period
  initial i_ref_clk = 1'b0;
  always #5 i_ref_clk = ~i_ref_clk;

  acrpm_core dut (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_sck(sck),
    .i_conv_strobe_n(strobe_n), .i_diff_sel(i_diff_sel),
    .i_sample_data(i_sample_data), .o_serial_out_pos(pos),
    .o_serial_out_neg(neg), .o_conv_busy(busy), .o_nap(nap),
    .o_sleep(sleep)
  );

  acrpm_host host (
    .i_ref_clk(i_ref_clk), .i_serial_out_pos(pos),
    .i_serial_out_neg(neg), .o_sck(sck), .o_conv_strobe_n(strobe_n)
  );

  // busy width counter and hang guard
  always @(posedge i_ref_clk) begin
    cycles++;
    if (busy === 1'b1) busy_len++;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic complete_run();
    if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run

  // conversion then full readout in the chosen signalling mode
  task automatic conv_read(input logic [15:0] d, input logic diff);
    logic [15:0] p;
    logic [15:0] n;
    logic        s;
    @(negedge i_ref_clk);
    i_diff_sel = diff;
    i_sample_data = d;
    repeat (6) @(negedge i_ref_clk);
    busy_len = 0;
    host.strobe();
    for (int k = 0; k < 60 && busy !== 1'b0; k++) @(negedge i_ref_clk);
    chk_word(16'(busy_len), 16'(acrpm_pkg::CONV_CYC));
    repeat (3) @(negedge i_ref_clk);
    host.read_word(p, n, s);
    chk_word(p, d);
    chk_word(n, diff ? ~d : 16'h0000);
    chk_bit(s, 1'b0);
  endtask : conv_read

  // idle serial clock: strobes walk operational, nap, sleep twice
  task automatic cycle_modes();
    i_diff_sel = 1'b1;
    for (int k = 1; k <= 10; k++) begin
      host.strobe();
      chk_bit(nap, (k % 5 == 2) || (k % 5 == 3));
      chk_bit(sleep, k % 5 == 4);
    end
  endtask : cycle_modes

  // serial clock leaves differential sleep alone, wakes single-ended nap and sleep
  task automatic sck_wake();
    repeat (4) host.strobe();
    host.sck_rise();
    chk_bit(sleep, 1'b1);
    host.strobe();
    chk_bit(sleep, 1'b0);
    i_diff_sel = 1'b0;
    repeat (2) host.strobe();
    chk_bit(nap, 1'b1);
    host.sck_rise();
    chk_bit(nap, 1'b0);
    repeat (4) host.strobe();
    chk_bit(sleep, 1'b1);
    host.sck_rise();
    chk_bit(sleep, 1'b0);
    repeat (20) @(negedge i_ref_clk); // recovery wait, scaled down
  endtask : sck_wake

  // serial clock between strobes keeps the device operational
  task automatic sck_blocks();
    host.strobe();
    host.sck_rise();
    host.strobe();
    chk_bit(nap, 1'b0);
  endtask : sck_blocks

  // reset in nap returns to operational and restarts the count
  task automatic mid_reset();
    repeat (2) host.strobe();
    @(negedge i_ref_clk);
    i_rstn = 1'b0;
    repeat (3) @(negedge i_ref_clk);
    chk_bit(nap, 1'b0);
    chk_bit(busy, 1'b0);
    i_rstn = 1'b1;
    repeat (2) host.strobe();
    chk_bit(nap, 1'b1);
  endtask : mid_reset

  initial begin
    num_errors = 0;
    tests_run = 0;
    cycles = 0;
    busy_len = 0;
    i_rstn = 1'b0;
    i_diff_sel = 1'b0;
    i_sample_data = 16'h0000;
    repeat (5) @(negedge i_ref_clk);
    i_rstn = 1'b1;
    repeat (2) @(negedge i_ref_clk); // power-on wait, scaled down
    conv_read(16'ha5c3, 1'b0);
    conv_read(16'h8001, 1'b1);
    cycle_modes();
    sck_wake();
    sck_blocks();
    mid_reset();
    complete_run();
  end
endmodule : acrpm_tb_top
